// ### design/tcc_top.sv
// Overview of operation
// - four sticky event flags, bits three to zero
// - writing one clears the event flag
// - flags set regardless of interrupt enable
// - flags forced zero while timer stopped
// - control layout: on, pol, irq, upd, mode
// - control registers at subaddress two to five
// - enable bit turns the channel off/on; here it gates chan_out only, chan_irq and the flags ignore it
// - polarity meaning follows the channel mode
// - disabled compare output equals polarity
// - one-shot output inverts one clock on match
// - continuous compare toggles on each match
// - mode codes: oneshot, cont, pwm, capture
// - channel interrupt only when irq enabled
// - compare writes buffered unless direct or stopped
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tcc_top #(
    parameter int unsigned N_CH  = 4,
    parameter int unsigned CMP_W = 16
) (
    // ahb-lite clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // timer core side
    input  wire logic [N_CH-1:0]   cc_event,
    input  wire logic [N_CH-1:0]   cmp_match,
    input  wire logic              end_of_count,
    input  wire logic [N_CH*CMP_W-1:0] cmp_wr_data,
    input  wire logic [N_CH-1:0]   cmp_wr,
    output logic      [N_CH*CMP_W-1:0] cmp_value,
    output logic                   timer_run,
    output logic      [N_CH-1:0]   chan_out,
    output logic      [N_CH-1:0]   chan_irq,
    // interrupt
    output logic                   irq
);
    if (N_CH != tcc_pkg::NUM_CH) begin : g_bad_ch
        $error("tcc_top supports four channels only");
    end
    if (CMP_W < 1 || CMP_W > 32) begin : g_bad_w
        $error("tcc_top compare width out of range");
    end

    tcc_pkg::tcc_req_s req_q;
    logic [7:0]        subaddr_q;
    logic [1:0]        subreg_q;
    logic [7:0]        tctl1_q;
    tcc_pkg::tcc_ctl_s ctl_q [N_CH];
    logic [N_CH-1:0]   flags;
    logic [N_CH-1:0]   clr;
    logic [N_CH-1:0]   irq_stat_q;
    logic [N_CH-1:0]   irq_mask_q;
    logic [CMP_W-1:0]  cmp_q [N_CH];
    logic [CMP_W-1:0]  cmp_pend_q [N_CH];
    logic [N_CH-1:0]   pend_q;
    logic              wr_en;
    logic              rd_stat;
    logic              data_wr;
    logic              data_rd;
    logic [31:0]       rdata_d;
    logic [N_CH-1:0]   irq_ev;

    function automatic logic is_ctl(input logic [7:0] sa,
                                    input logic [1:0] sr);
        is_ctl = (sr == tcc_pkg::SUBREG_CTL)
                 && (sa >= tcc_pkg::SUBADDR_CH_A)
                 && (sa <= tcc_pkg::SUBADDR_CH_D);
    endfunction

    function automatic logic [1:0] ctl_idx(input logic [7:0] sa);
        logic [7:0] d;
        d = sa - tcc_pkg::SUBADDR_CH_A;
        ctl_idx = d[1:0];
    endfunction

    // address phase capture; the slave never stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.valid <= hsel && htrans[1];
            req_q.write <= hwrite;
            req_q.addr  <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = req_q.valid && req_q.write;
    assign data_wr   = wr_en && (req_q.addr == tcc_pkg::OFF_DATA);
    assign data_rd   = req_q.valid && !req_q.write
                       && (req_q.addr == tcc_pkg::OFF_DATA);
    assign rd_stat   = req_q.valid && !req_q.write
                       && (req_q.addr == tcc_pkg::OFF_IRQ_STAT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            subaddr_q <= 8'h00;
            subreg_q  <= 2'h0;
            tctl1_q   <= tcc_pkg::TCTL1_RESET;
            irq_mask_q <= '0;
        end else if (wr_en) begin
            case (req_q.addr)
                tcc_pkg::OFF_SUBADDR:  subaddr_q  <= hwdata[7:0];
                tcc_pkg::OFF_SUBREG:   subreg_q   <= hwdata[1:0];
                tcc_pkg::OFF_TCTL1:    tctl1_q    <= hwdata[7:0];
                tcc_pkg::OFF_IRQ_MASK: irq_mask_q <= hwdata[N_CH-1:0];
                default: begin
                end
            endcase
        end
    end
    assign timer_run = tctl1_q[tcc_pkg::TCTL1_RUN_BIT];

    // channel control registers through the subaddress window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_CH; i++) begin
                ctl_q[i] <= tcc_pkg::CTL_RESET;
            end
        end else if (data_wr && is_ctl(subaddr_q, subreg_q)) begin
            // reserved bit three stays zero
            ctl_q[ctl_idx(subaddr_q)] <= hwdata[7:0] & tcc_pkg::CTL_WR_MASK;
        end
    end

    // write-one-to-clear of the event flags
    always_comb begin
        clr = '0;
        if (data_wr && subreg_q == tcc_pkg::SUBREG_STAT
            && subaddr_q == tcc_pkg::SUBADDR_STAT) begin
            clr = hwdata[N_CH-1:0];
        end
    end

    // irq enable is deliberately not an input here
    tcc_flags #(
        .N (N_CH)
    ) u_flags (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .timer_run          (timer_run),
        .event_in           (cc_event),
        .clear_in           (clr),
        .channel_event_flag (flags)
    );

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            tcc_chan_out u_out (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .ctl      (ctl_q[g]),
                .match    (cmp_match[g]),
                .chan_out (chan_out[g])
            );
            assign irq_ev[g] = cc_event[g]
                               && ctl_q[g].channel_irq_on;
            assign cmp_value[g*CMP_W +: CMP_W] = cmp_q[g];
        end
    endgenerate

    // compare value buffering
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N_CH; i++) begin
                cmp_q[i]      <= '0;
                cmp_pend_q[i] <= '0;
            end
            pend_q <= '0;
        end else begin
            for (int i = 0; i < N_CH; i++) begin
                if (cmp_wr[i]) begin
                    if (!timer_run || ctl_q[i].compare_update_direct) begin
                        cmp_q[i]  <= cmp_wr_data[i*CMP_W +: CMP_W];
                        pend_q[i] <= 1'b0;
                    end else begin
                        cmp_pend_q[i] <= cmp_wr_data[i*CMP_W +: CMP_W];
                        pend_q[i]     <= 1'b1;
                    end
                end else if (end_of_count && pend_q[i]) begin
                    cmp_q[i]  <= cmp_pend_q[i];
                    pend_q[i] <= 1'b0;
                end
            end
        end
    end

    // channel interrupt pulses and sticky status; event beats read-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_irq   <= '0;
            irq_stat_q <= '0;
        end else begin
            chan_irq   <= irq_ev;
            irq_stat_q <= (rd_stat ? '0 : irq_stat_q) | irq_ev;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (req_q.valid && !req_q.write) begin
            case (req_q.addr)
                tcc_pkg::OFF_SUBADDR:  rdata_d[7:0] = subaddr_q;
                tcc_pkg::OFF_SUBREG:   rdata_d[1:0] = subreg_q;
                tcc_pkg::OFF_TCTL1:    rdata_d[7:0] = tctl1_q;
                tcc_pkg::OFF_IRQ_STAT: rdata_d[N_CH-1:0] = irq_stat_q;
                tcc_pkg::OFF_IRQ_MASK: rdata_d[N_CH-1:0] = irq_mask_q;
                tcc_pkg::OFF_DATA: begin
                    if (is_ctl(subaddr_q, subreg_q)) begin
                        rdata_d[7:0] = ctl_q[ctl_idx(subaddr_q)];
                    end else if (subreg_q == tcc_pkg::SUBREG_STAT
                                 && subaddr_q == tcc_pkg::SUBADDR_STAT) begin
                        rdata_d[N_CH-1:0] = flags;
                    end
                end
                default: begin
                end
            endcase
        end
    end
    // combinational read data in the data phase; no stall needed
    assign hrdata = rdata_d;

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        cc_event[0] && !ctl_q[0].channel_irq_on |=> !chan_irq[0];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq raised while disabled");

    property p_irq_on;
        @(posedge hclk) disable iff (!hresetn)
        cc_event[1] && ctl_q[1].channel_irq_on |=> chan_irq[1];
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("irq missing");

    property p_rsv;
        @(posedge hclk) disable iff (!hresetn)
        ctl_q[1].reserved == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bit set");

    property p_buf;
        @(posedge hclk) disable iff (!hresetn)
        cmp_wr[2] && timer_run && !ctl_q[2].compare_update_direct
            |=> $stable(cmp_q[2]) && pend_q[2];
    endproperty
    a_buf: assert property (p_buf)
        else $error("buffered compare write applied early");

    property p_direct;
        @(posedge hclk) disable iff (!hresetn)
        cmp_wr[3] && (!timer_run || ctl_q[3].compare_update_direct)
            |=> cmp_q[3] == $past(cmp_wr_data[3*CMP_W +: CMP_W]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct compare write not applied");

    property p_load;
        @(posedge hclk) disable iff (!hresetn)
        end_of_count && pend_q[2] && !cmp_wr[2]
            |=> cmp_q[2] == $past(cmp_pend_q[2]) && !pend_q[2];
    endproperty
    a_load: assert property (p_load)
        else $error("pending compare not loaded at end of count");

    // a status bit may only drop through a read of the status word
    property p_stat_sticky;
        @(posedge hclk) disable iff (!hresetn)
        !rd_stat |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q);
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("irq status lost without a read");

    property p_rd_clear;
        @(posedge hclk) disable iff (!hresetn)
        rd_stat && (irq_ev == '0) |=> irq_stat_q == '0;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("irq status not cleared by read");

    property p_ctl_wr;
        @(posedge hclk) disable iff (!hresetn)
        data_wr && subreg_q == tcc_pkg::SUBREG_CTL
            && subaddr_q == tcc_pkg::SUBADDR_CH_A
            |=> ctl_q[0] == $past(hwdata[7:0] & tcc_pkg::CTL_WR_MASK);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr)
        else $error("channel control write not stored");

    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
    c_load: cover property (@(posedge hclk) disable iff (!hresetn)
        end_of_count && pend_q != '0);
    c_clr: cover property (@(posedge hclk) disable iff (!hresetn)
        clr != '0 && flags != '0);
endmodule

// ### design/tcc_pkg.sv
package tcc_pkg;

    localparam int unsigned NUM_CH = 4;

    // subregister selector values and subaddresses
    localparam logic [1:0] SUBREG_CTL    = 2'h2;
    localparam logic [1:0] SUBREG_STAT   = 2'h1;
    localparam logic [7:0] SUBADDR_STAT  = 8'h01;
    localparam logic [7:0] SUBADDR_CH_A  = 8'h02;
    localparam logic [7:0] SUBADDR_CH_D  = 8'h05;

    // bus byte offsets
    localparam logic [7:0] OFF_SUBADDR   = 8'h00;
    localparam logic [7:0] OFF_SUBREG    = 8'h04;
    localparam logic [7:0] OFF_DATA      = 8'h08;
    localparam logic [7:0] OFF_TCTL1     = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;

    // field positions of a channel control register and the TCTL1 run bit
    localparam int unsigned CTL_ON_BIT   = 7;
    localparam int unsigned CTL_POL_BIT  = 6;
    localparam int unsigned CTL_IRQ_BIT  = 5;
    localparam int unsigned CTL_UPD_BIT  = 4;
    localparam int unsigned CTL_RSV_BIT  = 3;
    localparam int unsigned TCTL1_RUN_BIT = 7;

    localparam logic [7:0] CTL_RESET     = 8'h00;
    localparam logic [7:0] CTL_WR_MASK   = 8'hf7;
    localparam logic [7:0] TCTL1_RESET   = 8'h00;
    localparam logic [3:0] FLAG_RESET    = 4'h0;

    typedef enum logic [2:0] {
        TCC_OP_ONESHOT = 3'b000,
        TCC_OP_CONT    = 3'b001,
        TCC_OP_PWM     = 3'b010,
        TCC_OP_CAPTURE = 3'b011
    } tcc_op_e;

    typedef struct packed {
        logic       channel_on;
        logic       channel_polarity;
        logic       channel_irq_on;
        logic       compare_update_direct;
        logic       reserved;
        logic [2:0] channel_op_select;
    } tcc_ctl_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } tcc_req_s;

endpackage

// ### design/tcc_flags.sv
`timescale 1ns/1ps
module tcc_flags #(
    parameter int unsigned N = 4
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // control
    input  wire logic         timer_run,
    input  wire logic [N-1:0] event_in,
    input  wire logic [N-1:0] clear_in,
    // flags
    output logic      [N-1:0] channel_event_flag
);
    logic [N-1:0] flag_q;

    // a new event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= '0;
        end else if (!timer_run) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~clear_in) | event_in;
        end
    end
    assign channel_event_flag = flag_q;

    property p_run_clear;
        @(posedge hclk) disable iff (!hresetn)
        !timer_run |=> flag_q == '0;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("flags not cleared while stopped");

    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        timer_run && (event_in != '0) |=> (flag_q & $past(event_in))
            == $past(event_in);
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        timer_run && (clear_in != '0) && (event_in == '0) |=>
            (flag_q & $past(clear_in)) == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("write one did not clear flag");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        timer_run && $past(timer_run) && (event_in == '0)
            && (clear_in == '0) |=> flag_q == $past(flag_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("flag changed without cause");

    c_set: cover property (@(posedge hclk) disable iff (!hresetn)
        flag_q != '0);
endmodule

// ### design/tcc_chan_out.sv
`timescale 1ns/1ps
module tcc_chan_out (
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // control
    input  wire tcc_pkg::tcc_ctl_s ctl,
    input  wire logic            match,
    // output
    output logic                 chan_out
);
    logic out_q;
    logic on;
    logic pol;
    logic is_cmp;

    assign on     = ctl.channel_on;
    assign pol    = ctl.channel_polarity;
    // polarity meaning depends on the mode
    assign is_cmp = (ctl.channel_op_select == tcc_pkg::TCC_OP_ONESHOT) ||
                    (ctl.channel_op_select == tcc_pkg::TCC_OP_CONT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 1'b0;
        end else if (!on) begin
            // pwm and capture idle low; compare idles at polarity
            out_q <= is_cmp ? pol : 1'b0;
        end else begin
            case (ctl.channel_op_select)
                tcc_pkg::TCC_OP_ONESHOT: begin
                    out_q <= match ? ~pol : pol;
                end
                tcc_pkg::TCC_OP_CONT: begin
                    out_q <= match ? ~out_q : out_q;
                end
                default: begin
                    out_q <= out_q;
                end
            endcase
        end
    end
    assign chan_out = out_q;

    property p_idle;
        @(posedge hclk) disable iff (!hresetn)
        !on && is_cmp |=> out_q == $past(pol);
    endproperty
    a_idle: assert property (p_idle)
        else $error("disabled compare output not at polarity");

    property p_pulse;
        @(posedge hclk) disable iff (!hresetn)
        on && ctl.channel_op_select == tcc_pkg::TCC_OP_ONESHOT && match
            && $stable(ctl) ##1 !match && $stable(ctl) |=>
            $past(out_q) != $past(pol) ##0 out_q == $past(pol);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("one-shot pulse not one cycle");

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        on && ctl.channel_op_select == tcc_pkg::TCC_OP_CONT && match
            |=> out_q != $past(out_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("continuous compare did not toggle");

    c_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
        on && match && ctl.channel_op_select == tcc_pkg::TCC_OP_CONT);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  cc_event;
    logic [3:0]  cmp_match;
    logic        end_of_count;
    logic [63:0] cmp_wr_data;
    logic [3:0]  cmp_wr;
    logic [63:0] cmp_value;
    logic        timer_run;
    logic [3:0]  chan_out;
    logic [3:0]  chan_irq;
    logic        irq;
    logic [31:0] rd;
    int          error_cnt;
    int          cmp_count;

    // single slave, so its hreadyout is the bus hready
    assign hready = hreadyout;

    tcc_top #(.N_CH(4), .CMP_W(16)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cc_event(cc_event), .cmp_match(cmp_match),
        .end_of_count(end_of_count), .cmp_wr_data(cmp_wr_data),
        .cmp_wr(cmp_wr), .cmp_value(cmp_value), .timer_run(timer_run),
        .chan_out(chan_out), .chan_irq(chan_irq), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one single word transfer; ev is raised in the data phase so that an
    // event can land on the same edge as a write
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] ev);
        int n;
        n = 0;
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsel   <= 1'b1;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        htrans   <= 2'b00;
        hwdata   <= wd;
        cc_event <= ev;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        cc_event <= 4'h0;
        hsel     <= 1'b0;
        check("hresp", {31'h0, hresp}, 32'h0);
        if (hready !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH bus wait expired");
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, a, {24'h0, d}, 4'h0);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [7:0] exp);
        ahb(1'b0, a, 32'h0, 4'h0);
        check(name, rd, {24'h0, exp});
    endtask

    // one-cycle pulse on the timer core inputs, then sample after the edge
    task automatic strobe(input logic [3:0] ev, input logic [3:0] mt,
                          input logic eoc, input logic [3:0] w);
        @(posedge hclk);
        cc_event     <= ev;
        cmp_match    <= mt;
        end_of_count <= eoc;
        cmp_wr       <= w;
        @(posedge hclk);
        cc_event     <= 4'h0;
        cmp_match    <= 4'h0;
        end_of_count <= 1'b0;
        cmp_wr       <= 4'h0;
        #1;
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        cc_event = 4'h0;
        cmp_match = 4'h0;
        end_of_count = 1'b0;
        cmp_wr_data = 64'h0;
        cmp_wr = 4'h0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("timer_control_one", tcc_pkg::OFF_TCTL1, 8'h0);
        rd_chk("irq_mask", tcc_pkg::OFF_IRQ_MASK, 8'h0);
        wr(tcc_pkg::OFF_SUBREG, {6'h0, tcc_pkg::SUBREG_CTL});
        for (int i = 0; i < 4; i++) begin
            wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A + 8'(i));
            rd_chk("ctl_reset", tcc_pkg::OFF_DATA, 8'h0);
        end
        // every mode code, spread over the four channels
        for (int i = 0; i < 8; i++) begin
            wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A + 8'(i % 4));
            wr(tcc_pkg::OFF_DATA, 8'hf8 | 8'(i));
            rd_chk("ctl_mode", tcc_pkg::OFF_DATA,
                   8'hf0 | 8'(i));
        end
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A);
        rd_chk("ctl_a_kept", tcc_pkg::OFF_DATA, 8'hf4);
        for (int i = 0; i < 4; i++) begin
            wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A + 8'(i));
            wr(tcc_pkg::OFF_DATA, 8'h0);
        end
        wr(8'h18, 8'hff);
        rd_chk("unmapped", 8'h18, 8'h0);
        // disabled outputs: one-shot follows polarity, pwm does not
        wr(tcc_pkg::OFF_DATA, 8'h42);
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A);
        wr(tcc_pkg::OFF_DATA, 8'h40);
        strobe(4'h0, 4'h0, 1'b0, 4'h0);
        check("out_a_off", {31'h0, chan_out[0]}, 32'h1);
        check("out_d_pwm", {31'h0, chan_out[3]}, 32'h0);
        wr(tcc_pkg::OFF_DATA, 8'hc0);
        strobe(4'h0, 4'h1, 1'b0, 4'h0);
        check("oneshot_hit", {31'h0, chan_out[0]}, 32'h0);
        strobe(4'h0, 4'h0, 1'b0, 4'h0);
        check("oneshot_back", {31'h0, chan_out[0]}, 32'h1);
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A + 8'h1);
        wr(tcc_pkg::OFF_DATA, 8'h01);
        wr(tcc_pkg::OFF_DATA, 8'h81);
        strobe(4'h0, 4'h2, 1'b0, 4'h0);
        check("cont_first", {31'h0, chan_out[1]}, 32'h1);
        strobe(4'h0, 4'h2, 1'b0, 4'h0);
        check("cont_second", {31'h0, chan_out[1]}, 32'h0);
        // event flags with the timer running
        wr(tcc_pkg::OFF_TCTL1, 8'h80);
        #1;
        check("timer_run", {31'h0, timer_run}, 32'h1);
        wr(tcc_pkg::OFF_SUBREG, {6'h0, tcc_pkg::SUBREG_STAT});
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_STAT);
        strobe(4'h5, 4'h0, 1'b0, 4'h0);
        check("irq_off", {28'h0, chan_irq}, 32'h0);
        rd_chk("flags_set", tcc_pkg::OFF_DATA, 8'h05);
        wr(tcc_pkg::OFF_DATA, 8'h00);
        rd_chk("flags_zero_wr", tcc_pkg::OFF_DATA, 8'h05);
        wr(tcc_pkg::OFF_DATA, 8'h01);
        rd_chk("flags_w1c", tcc_pkg::OFF_DATA, 8'h04);
        ahb(1'b1, tcc_pkg::OFF_DATA, 32'h4, 4'h4);
        rd_chk("flags_race", tcc_pkg::OFF_DATA, 8'h04);
        wr(tcc_pkg::OFF_DATA, 8'h04);
        rd_chk("flags_w1c_c", tcc_pkg::OFF_DATA, 8'h00);
        strobe(4'h8, 4'h0, 1'b0, 4'h0);
        wr(tcc_pkg::OFF_TCTL1, 8'h00);
        rd_chk("flags_stopped", tcc_pkg::OFF_DATA, 8'h00);
        wr(tcc_pkg::OFF_TCTL1, 8'h80);
        rd_chk("flags_restart", tcc_pkg::OFF_DATA, 8'h00);
        // interrupt raise, read-clear and mask
        wr(tcc_pkg::OFF_IRQ_MASK, 8'h02);
        wr(tcc_pkg::OFF_SUBREG, {6'h0, tcc_pkg::SUBREG_CTL});
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_A + 8'h1);
        wr(tcc_pkg::OFF_DATA, 8'ha1);
        strobe(4'h3, 4'h0, 1'b0, 4'h0);
        check("chan_irq", {28'h0, chan_irq}, 32'h2);
        check("irq_up", {31'h0, irq}, 32'h1);
        rd_chk("irq_status", tcc_pkg::OFF_IRQ_STAT, 8'h02);
        strobe(4'h0, 4'h0, 1'b0, 4'h0);
        check("irq_cleared", {31'h0, irq}, 32'h0);
        wr(tcc_pkg::OFF_IRQ_MASK, 8'h00);
        strobe(4'h2, 4'h0, 1'b0, 4'h0);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("irq_status_m", tcc_pkg::OFF_IRQ_STAT, 8'h02);
        // compare writes: c buffered, d direct, then c with timer stopped
        wr(tcc_pkg::OFF_SUBADDR, tcc_pkg::SUBADDR_CH_D);
        wr(tcc_pkg::OFF_DATA, 8'h10);
        @(posedge hclk);
        cmp_wr_data <= {16'habcd, 16'h1234, 32'h0};
        strobe(4'h0, 4'h0, 1'b0, 4'hc);
        check("cmp_held", cmp_value[63:32], 32'habcd_0000);
        strobe(4'h0, 4'h0, 1'b1, 4'h0);
        check("cmp_loaded", cmp_value[63:32], 32'habcd_1234);
        wr(tcc_pkg::OFF_TCTL1, 8'h00);
        @(posedge hclk);
        cmp_wr_data <= {16'h0, 16'h5555, 32'h0};
        strobe(4'h0, 4'h0, 1'b0, 4'h4);
        check("cmp_stopped", cmp_value[63:32], 32'habcd_5555);
        report_and_stop();
    end
endmodule
